// >>> rcl_defs.svh
// Constants for the reset control logic: rule summary, cycle counts and cause bit positions.
// Contract
// - Three independent reset outputs: pin, clock, internal.
// - All five main sources assert every output.
// - Synchronous sources wait for bus cycle end.
// - Bus monitor forced on for synchronous resets.
// - Only byte or word transfers stay valid.
// - Asynchronous sources reset immediately, no bus wait.
// - Reset ends bus cycle like an acknowledge.
// - Registers initialised for the reset exception.
// - Internal reset held while pin held externally.
// - After pin release, drive everything 512 more.
// - Other sources: pin 512 cycles, longer if held.
// - 14-cycle rise time, then vector fetch.
// - Bus floats or idles during reset.
// - On release: bus idle, read, address, fetch.
// - Reset instruction drives only pin, 512 cycles.
`ifndef RCL_DEFS_SVH
`define RCL_DEFS_SVH

// ------------------------------------------------------------------
// Cycle counts
// ------------------------------------------------------------------
`define RCL_CNT_W 10
`define RCL_STRETCH_CYC 10'h200
`define RCL_RISE_CYC 10'h00E
`define RCL_EXT_HOLD_MIN_CYC 10'h24E

// ------------------------------------------------------------------
// Cause bit positions
// ------------------------------------------------------------------
`define RCL_CAUSE_W 6
`define RCL_CAUSE_EXT 0
`define RCL_CAUSE_PWR 1
`define RCL_CAUSE_WDOG 2
`define RCL_CAUSE_DBF 3
`define RCL_CAUSE_LOC 4
`define RCL_CAUSE_INSTR 5
`define RCL_CAUSE_RST_VAL 6'h02

`endif

// >>> rcl_pkg.sv
// Types shared by the reset control logic.
package rcl_pkg;
    // One-hot sequencer states.
    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_WAIT_BUS = 8'h02,
        ST_EXT_HOLD = 8'h04,
        ST_STRETCH  = 8'h08,
        ST_RISE     = 8'h10,
        ST_INSTR    = 8'h20,
        ST_START    = 8'h40
    } rcl_state_t;
endpackage

// >>> rcl_sync.sv
// Three-flop pin synchroniser with agreement filter.
`timescale 1ns/10ps
module rcl_sync (
    input wire logic clk_i,    // System clock.
    input wire logic arst_n_i, // Asynchronous reset, active low.
    input wire logic pin_i,    // Raw pin level.
    output logic level_o       // Filtered level.
);
    logic s1_q, s2_q, s3_q; // Synchroniser chain.
    logic level_q, level_d; // Accepted level.

    // ------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------
    // A change counts only once the second and third stages agree.
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    // The chain and the filter reset to the idle, released level.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule

// >>> rcl_down_cnt.sv
// Loadable down counter that flags when it reaches zero.
`timescale 1ns/10ps
`include "rcl_defs.svh"
module rcl_down_cnt (
    input wire logic clk_i,                     // System clock.
    input wire logic arst_n_i,                  // Asynchronous reset, active low.
    input wire logic load_i,                    // Load strobe.
    input wire logic [`RCL_CNT_W-1:0] value_i,  // Value loaded.
    output logic zero_o                         // Count is zero.
);
    logic [`RCL_CNT_W-1:0] cnt_q, cnt_d; // Remaining count.

    // Load wins over counting; the count sticks at zero.
    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = value_i;
        end else if (cnt_q != 10'h000) begin
            cnt_d = cnt_q - 10'h001;
        end
    end

    // Power-up counts the full stretch straight away.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= `RCL_STRETCH_CYC - 10'h001;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign zero_o = (cnt_q == 10'h000);
endmodule

// >>> rcl_top.sv
// Reset control logic: cause capture, sequencing and reset line drive.
`timescale 1ns/10ps
`include "rcl_defs.svh"
module rcl_top (
    input wire logic CORE_CLK_I,             // System clock, 200 MHz.
    input wire logic ARST_N_I,               // Power-up reset, active low.
    input wire logic RESET_PIN_I,            // Reset pin level read back.
    output logic RESET_PIN_O,                // Reset pin drive value, always low.
    output logic RESET_PIN_OE_O,             // Reset pin driven when high.
    output logic CLOCK_MODULE_RESET_O,       // Clock module reset, active high.
    output logic INTERNAL_CIRCUIT_RESET_O,   // Internal circuits reset, active high.
    input wire logic WDOG_RESET_I,           // Watchdog reset request, level.
    input wire logic DBL_FAULT_RESET_I,      // Double-fault reset request, level.
    input wire logic LOSS_OF_CLOCK_I,        // Loss-of-clock request, level.
    input wire logic RESET_INSTR_I,          // Reset instruction, one-cycle pulse.
    input wire logic BUS_CYCLE_ACTIVE_I,     // A bus cycle is in progress.
    input wire logic BUS_CYCLE_END_I,        // Current bus cycle ends this cycle.
    input wire logic READ_MODIFY_WRITE_LOCK_I, // Locked sequence in progress.
    input wire logic XFER_LONG_I,            // Current operand wider than a word.
    output logic BUS_MONITOR_FORCE_O,        // Force the bus monitor on.
    output logic DATA_SIZE_ACK_O,            // Terminate cycle as acknowledged.
    output logic BUS_HIZ_O,                  // Float the bus, idle the rest.
    output logic BUS_IDLE_DRIVE_O,           // Controls idle, read, address driven.
    output logic VECTOR_FETCH_O,             // Start reset exception fetch, pulse.
    output logic XFER_INVALID_O,             // Cut transfer not guaranteed valid.
    output logic [`RCL_CAUSE_W-1:0] CAUSE_O  // Cause of the latest reset.
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rcl_pkg::rcl_state_t state_q, state_d;  // Sequencer state.
    logic instr_q, instr_d;                 // Current sequence is the instruction one.
    logic ext_pend_q, ext_pend_d;           // Pending synchronous source is the pin.
    logic [`RCL_CAUSE_W-1:0] cause_q, cause_d; // Cause bits.
    logic xinv_q, xinv_d;                   // Long transfer was cut.
    logic pin_oe_q, pin_oe_d;               // Pin output enable.
    logic clk_rst_q, clk_rst_d;             // Clock module reset.
    logic int_rst_q, int_rst_d;             // Internal reset.
    logic mon_q, mon_d;                     // Bus monitor force.
    logic ack_q, ack_d;                     // Forced termination.
    logic hiz_q, hiz_d;                     // Bus float.
    logic idle_q, idle_d;                   // Bus idle drive.
    logic fetch_q, fetch_d;                 // Vector fetch pulse.
    logic pin_lvl;                          // Filtered pin level.
    logic cnt_load;                         // Counter load.
    logic [`RCL_CNT_W-1:0] cnt_val;         // Counter load value.
    logic cnt_zero;                         // Counter expired.
    logic async_src;                        // Any asynchronous source active.
    logic held_src;                         // Any non-pin source still asserted.
    logic ext_seen;                         // Pin pulled low by another party.
    logic bus_free;                         // Bus cycle finished or none.

    // ------------------------------------------------------------------
    // Pin synchroniser and cycle counter
    // ------------------------------------------------------------------
    rcl_sync u_pin_sync (
        .clk_i(CORE_CLK_I),
        .arst_n_i(ARST_N_I),
        .pin_i(RESET_PIN_I),
        .level_o(pin_lvl)
    );

    rcl_down_cnt u_cnt (
        .clk_i(CORE_CLK_I),
        .arst_n_i(ARST_N_I),
        .load_i(cnt_load),
        .value_i(cnt_val),
        .zero_o(cnt_zero)
    );

    // The pin is only ever pulled low; the enable decides the level.
    assign RESET_PIN_O = 1'b0;

    // Source classification.
    assign async_src = WDOG_RESET_I | DBL_FAULT_RESET_I;
    assign held_src = async_src | LOSS_OF_CLOCK_I;
    // Our own drive also pulls the pin down, so the pin is only believed
    // while we are not driving it.
    assign ext_seen = ~pin_lvl & ~pin_oe_q;
    // The lock signal is deliberately not looked at here.
    assign bus_free = BUS_CYCLE_END_I | ~BUS_CYCLE_ACTIVE_I;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // Asynchronous sources win from every state except ST_STRETCH and restart the stretch.
    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        ext_pend_d = ext_pend_q;
        cause_d = cause_q;
        xinv_d = xinv_q;
        cnt_load = 1'b0;
        cnt_val = `RCL_STRETCH_CYC - 10'h001;
        if (async_src && (state_q != rcl_pkg::ST_STRETCH || instr_q)) begin
            // Immediate reset, bus cycle abandoned.
            state_d = rcl_pkg::ST_STRETCH;
            instr_d = 1'b0;
            cnt_load = 1'b1;
            cause_d = '0;
            cause_d[`RCL_CAUSE_WDOG] = WDOG_RESET_I;
            cause_d[`RCL_CAUSE_DBF] = DBL_FAULT_RESET_I;
        end else begin
            case (state_q)
                rcl_pkg::ST_IDLE: begin
                    if (ext_seen || LOSS_OF_CLOCK_I) begin
                        // Synchronous source: wait for the bus.
                        state_d = rcl_pkg::ST_WAIT_BUS;
                        ext_pend_d = ext_seen;
                    end else if (RESET_INSTR_I) begin
                        state_d = rcl_pkg::ST_INSTR;
                        instr_d = 1'b1;
                        cnt_load = 1'b1;
                        cause_d = '0;
                        cause_d[`RCL_CAUSE_INSTR] = 1'b1;
                    end
                end
                rcl_pkg::ST_WAIT_BUS: begin
                    if (bus_free) begin
                        cause_d = '0;
                        cause_d[`RCL_CAUSE_EXT] = ext_pend_q;
                        cause_d[`RCL_CAUSE_LOC] = ~ext_pend_q;
                        // Only byte or word transfers complete in one cycle.
                        xinv_d = BUS_CYCLE_ACTIVE_I & XFER_LONG_I;
                        instr_d = 1'b0;
                        if (ext_pend_q) begin
                            state_d = rcl_pkg::ST_EXT_HOLD;
                        end else begin
                            state_d = rcl_pkg::ST_STRETCH;
                            cnt_load = 1'b1;
                        end
                    end
                end
                rcl_pkg::ST_EXT_HOLD: begin
                    // Internal reset stays on until the other party lets go.
                    if (pin_lvl) begin
                        state_d = rcl_pkg::ST_STRETCH;
                        cnt_load = 1'b1;
                    end
                end
                rcl_pkg::ST_STRETCH: begin
                    // Minimum stretch, extended while a source is still held.
                    if (cnt_zero && !held_src) begin
                        state_d = rcl_pkg::ST_RISE;
                        cnt_load = 1'b1;
                        cnt_val = `RCL_RISE_CYC - 10'h001;
                    end
                end
                rcl_pkg::ST_INSTR: begin
                    if (cnt_zero) begin
                        state_d = rcl_pkg::ST_RISE;
                        cnt_load = 1'b1;
                        cnt_val = `RCL_RISE_CYC - 10'h001;
                    end
                end
                rcl_pkg::ST_RISE: begin
                    // Pin released; give it time to rise before trusting it.
                    if (cnt_zero) begin
                        if (!pin_lvl) begin
                            state_d = rcl_pkg::ST_EXT_HOLD;
                            instr_d = 1'b0;
                            cause_d = '0;
                            cause_d[`RCL_CAUSE_EXT] = 1'b1;
                        end else if (instr_q) begin
                            state_d = rcl_pkg::ST_IDLE;
                            instr_d = 1'b0;
                        end else begin
                            state_d = rcl_pkg::ST_START;
                        end
                    end
                end
                rcl_pkg::ST_START: begin
                    state_d = rcl_pkg::ST_IDLE;
                    xinv_d = 1'b0;
                end
                default: begin
                    state_d = rcl_pkg::ST_STRETCH;
                    instr_d = 1'b0;
                    cnt_load = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------------
    // Outputs are decoded from the next state so that every one of them
    // comes from a flop and changes together with the state.
    always_comb begin
        pin_oe_d = 1'b0;
        clk_rst_d = 1'b0;
        int_rst_d = 1'b0;
        mon_d = 1'b0;
        hiz_d = 1'b0;
        idle_d = 1'b0;
        fetch_d = 1'b0;
        case (state_d)
            rcl_pkg::ST_WAIT_BUS: begin
                mon_d = 1'b1;
            end
            rcl_pkg::ST_EXT_HOLD: begin
                clk_rst_d = 1'b1;
                int_rst_d = 1'b1;
            end
            rcl_pkg::ST_STRETCH: begin
                pin_oe_d = 1'b1;
                clk_rst_d = 1'b1;
                int_rst_d = 1'b1;
            end
            rcl_pkg::ST_INSTR: begin
                pin_oe_d = 1'b1;
            end
            rcl_pkg::ST_RISE: begin
                int_rst_d = ~instr_d;
            end
            rcl_pkg::ST_START: begin
                idle_d = 1'b1;
                fetch_d = 1'b1;
            end
            default: begin
                pin_oe_d = 1'b0;
            end
        endcase
        // The bus floats for as long as the internal reset lasts.
        hiz_d = int_rst_d;
        // A cycle caught by the reset is closed as if acknowledged.
        ack_d = int_rst_d & BUS_CYCLE_ACTIVE_I;
    end

    // ------------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------------
    // Power-up is asynchronous: reset lands in the stretch with every
    // line asserted, so the system sees at least the full stretch.
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_q <= rcl_pkg::ST_STRETCH;
            instr_q <= 1'b0;
            ext_pend_q <= 1'b0;
            cause_q <= `RCL_CAUSE_RST_VAL;
            xinv_q <= 1'b0;
            pin_oe_q <= 1'b1;
            clk_rst_q <= 1'b1;
            int_rst_q <= 1'b1;
            mon_q <= 1'b0;
            ack_q <= 1'b0;
            hiz_q <= 1'b1;
            idle_q <= 1'b0;
            fetch_q <= 1'b0;
        end else begin
            state_q <= state_d;
            instr_q <= instr_d;
            ext_pend_q <= ext_pend_d;
            cause_q <= cause_d;
            xinv_q <= xinv_d;
            pin_oe_q <= pin_oe_d;
            clk_rst_q <= clk_rst_d;
            int_rst_q <= int_rst_d;
            mon_q <= mon_d;
            ack_q <= ack_d;
            hiz_q <= hiz_d;
            idle_q <= idle_d;
            fetch_q <= fetch_d;
        end
    end

    // ------------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------------
    assign RESET_PIN_OE_O = pin_oe_q;
    assign CLOCK_MODULE_RESET_O = clk_rst_q;
    // The internal reset is what initialises registers for the exception.
    assign INTERNAL_CIRCUIT_RESET_O = int_rst_q;
    assign BUS_MONITOR_FORCE_O = mon_q;
    assign DATA_SIZE_ACK_O = ack_q;
    assign BUS_HIZ_O = hiz_q;
    assign BUS_IDLE_DRIVE_O = idle_q;
    assign VECTOR_FETCH_O = fetch_q;
    assign XFER_INVALID_O = xinv_q;
    assign CAUSE_O = cause_q;
endmodule

// >>> rcl_top_sva.sv
// Concurrent checks on the ports of the reset control logic.
`timescale 1ns/10ps
module rcl_top_chk (
    input wire logic CORE_CLK_I, // Clock.
    input wire logic ARST_N_I, // Reset, active low.
    input wire logic RESET_PIN_I, // Pin level.
    input wire logic RESET_PIN_OE_O, // Pin pulled.
    input wire logic CLOCK_MODULE_RESET_O, // Clock reset.
    input wire logic INTERNAL_CIRCUIT_RESET_O, // Internal reset.
    input wire logic WDOG_RESET_I, // Watchdog.
    input wire logic DBL_FAULT_RESET_I, // Double fault.
    input wire logic LOSS_OF_CLOCK_I, // Loss of clock.
    input wire logic BUS_CYCLE_ACTIVE_I, // Bus busy.
    input wire logic BUS_CYCLE_END_I, // Bus cycle ends.
    input wire logic BUS_MONITOR_FORCE_O, // Monitor forced.
    input wire logic DATA_SIZE_ACK_O, // Cycle ended.
    input wire logic BUS_HIZ_O, // Bus floated.
    input wire logic BUS_IDLE_DRIVE_O, // Bus driven idle.
    input wire logic VECTOR_FETCH_O // Fetch start.
);
    // ------------------------------------------------------------
    // Run counters
    // ------------------------------------------------------------
    logic [9:0] rise_q; // Cycles of the current rise window.
    logic [9:0] rise_d; // Next rise count.
    logic [9:0] oe_q; // Cycles of the current pin drive run.
    logic [9:0] oe_d; // Next pin drive count.
    // The pin count saturates so a long held source cannot wrap below 512.
    always_comb begin
        rise_d = 10'h000;
        oe_d = 10'h000;
        if (INTERNAL_CIRCUIT_RESET_O && !CLOCK_MODULE_RESET_O && !RESET_PIN_OE_O) begin
            rise_d = rise_q + 10'h001;
        end
        if (RESET_PIN_OE_O) begin
            oe_d = (oe_q == 10'h3FF) ? oe_q : oe_q + 10'h001;
        end
    end
    // Counters only register their next values.
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rise_q <= 10'h000;
            oe_q <= 10'h000;
        end else begin
            rise_q <= rise_d;
            oe_q <= oe_d;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence async_req;
        (WDOG_RESET_I || DBL_FAULT_RESET_I) && !CLOCK_MODULE_RESET_O;
    endsequence
    sequence all_high;
        CLOCK_MODULE_RESET_O && INTERNAL_CIRCUIT_RESET_O && RESET_PIN_OE_O;
    endsequence
    sequence sync_pend;
        LOSS_OF_CLOCK_I && !WDOG_RESET_I && !DBL_FAULT_RESET_I && BUS_CYCLE_ACTIVE_I
            && !BUS_CYCLE_END_I && !BUS_MONITOR_FORCE_O;
    endsequence
    a_three_lines: assert property (
        RESET_PIN_OE_O && !CLOCK_MODULE_RESET_O |-> !INTERNAL_CIRCUIT_RESET_O)
        else $error("pin drive without clock reset also reset internals");
    a_async_now: assert property (async_req |=> all_high)
        else $error("asynchronous source not applied on the next edge");
    a_sync_waits: assert property (
        BUS_MONITOR_FORCE_O && BUS_CYCLE_ACTIVE_I && !BUS_CYCLE_END_I
        && !WDOG_RESET_I && !DBL_FAULT_RESET_I |=> !CLOCK_MODULE_RESET_O)
        else $error("synchronous reset applied before bus cycle end");
    a_monitor_on: assert property (
        sync_pend and (!INTERNAL_CIRCUIT_RESET_O && !RESET_PIN_OE_O)
        |-> ##[1:20] BUS_MONITOR_FORCE_O)
        else $error("bus monitor not forced for synchronous reset");
    a_ack_cycle: assert property (
        INTERNAL_CIRCUIT_RESET_O && BUS_CYCLE_ACTIVE_I ##1 INTERNAL_CIRCUIT_RESET_O
        |-> DATA_SIZE_ACK_O)
        else $error("bus cycle not terminated by reset");
    a_ext_hold: assert property (
        INTERNAL_CIRCUIT_RESET_O && CLOCK_MODULE_RESET_O && !RESET_PIN_OE_O && !RESET_PIN_I
        |=> INTERNAL_CIRCUIT_RESET_O)
        else $error("internal reset dropped while pin held low");
    a_stretch_min: assert property ($fell(RESET_PIN_OE_O) |-> oe_q >= 10'h200)
        else $error("pin drive shorter than 512 cycles");
    a_rise_gap: assert property (VECTOR_FETCH_O |-> rise_q == 10'h00E)
        else $error("rise window not 14 cycles");
    a_bus_float: assert property (BUS_HIZ_O == INTERNAL_CIRCUIT_RESET_O)
        else $error("bus float differs from internal reset");
    a_fetch_pair: assert property (
        VECTOR_FETCH_O |-> BUS_IDLE_DRIVE_O && !BUS_HIZ_O ##1 !VECTOR_FETCH_O)
        else $error("fetch start not a single idle drive cycle");
endmodule
bind rcl_top rcl_top_chk chk_u (.CORE_CLK_I, .ARST_N_I, .RESET_PIN_I, .RESET_PIN_OE_O,
    .CLOCK_MODULE_RESET_O, .INTERNAL_CIRCUIT_RESET_O, .WDOG_RESET_I, .DBL_FAULT_RESET_I,
    .LOSS_OF_CLOCK_I, .BUS_CYCLE_ACTIVE_I, .BUS_CYCLE_END_I, .BUS_MONITOR_FORCE_O,
    .DATA_SIZE_ACK_O, .BUS_HIZ_O, .BUS_IDLE_DRIVE_O, .VECTOR_FETCH_O);

// >>> rcl_pin_partner.sv
// External device that pulls the shared reset line low for a set time.
`timescale 1ns/10ps
module rcl_pin_partner (
    input wire logic clk_i, // System clock.
    input wire logic go_i, // Start one pull.
    input wire logic [15:0] hold_i, // Cycles to hold the line low.
    output logic pull_o // High while the line is pulled low.
);
    logic [15:0] left_q = 16'h0000; // Cycles still to hold.
    // --------------------------------------------------------
    // Pull timing
    // --------------------------------------------------------
    // Callers ask for at least 590 cycles, or the device may miss it.
    always @(posedge clk_i) begin
        if (go_i) begin
            left_q <= hold_i;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
        end
    end
    assign pull_o = (left_q != 16'h0000);
endmodule

// >>> rcl_top_bench.sv
// Self-checking bench for the reset control logic.
`timescale 1ns/10ps
module rcl_top_bench;
    // --------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------
    logic clk = 1'b0; // System clock.
    logic arst_n = 1'b0; // Power-up reset.
    logic wdog = 1'b0, dbl = 1'b0, loss = 1'b0, instr = 1'b0; // Sources.
    logic act = 1'b0, bend = 1'b0, lock = 1'b0, xlong = 1'b0; // Bus state.
    logic p_go = 1'b0; // Partner start.
    logic [15:0] p_hold = 16'h0000; // Partner hold time.
    logic pull, pin_o, oe, ckr, intr, mon, ack, hiz, idle, vf, xinv; // Outputs.
    logic pin_w; // Wire level with pull-up.
    logic [5:0] cause; // Reported cause.
    logic [21:0] notes[$]; // Expected cause and minimum pin run.
    logic [21:0] note; // Note being checked.
    logic [31:0] seed = 32'h0000C405; // Random state.
    logic [31:0] r; // Last random value.
    int fails = 0, compares = 0, run = 0, rise = 0, hold; // Counters.
    always #2.5 clk = ~clk;
    // The line is low when either party pulls it; otherwise the pull-up wins.
    assign pin_w = !pull && (oe ? pin_o : 1'b1);
    rcl_pin_partner part_u (.clk_i(clk), .go_i(p_go), .hold_i(p_hold), .pull_o(pull));
    rcl_top dut_u (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .RESET_PIN_I(pin_w),
        .RESET_PIN_O(pin_o), .RESET_PIN_OE_O(oe), .CLOCK_MODULE_RESET_O(ckr),
        .INTERNAL_CIRCUIT_RESET_O(intr), .WDOG_RESET_I(wdog), .DBL_FAULT_RESET_I(dbl),
        .LOSS_OF_CLOCK_I(loss), .RESET_INSTR_I(instr), .BUS_CYCLE_ACTIVE_I(act),
        .BUS_CYCLE_END_I(bend), .READ_MODIFY_WRITE_LOCK_I(lock), .XFER_LONG_I(xlong),
        .BUS_MONITOR_FORCE_O(mon), .DATA_SIZE_ACK_O(ack), .BUS_HIZ_O(hiz),
        .BUS_IDLE_DRIVE_O(idle), .VECTOR_FETCH_O(vf), .XFER_INVALID_O(xinv),
        .CAUSE_O(cause));
    // --------------------------------------------------------
    // Helpers
    // --------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Both processes call this, so it must not share argument storage.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Wait, bounded, until every reset line is quiet, then let the block idle.
    task automatic settle(input string name);
        int n;
        n = 0;
        while ({oe, ckr, intr} !== 3'h0 && n < 6000) begin
            @(negedge clk);
            n++;
        end
        chk(n < 6000, 1);
        cyc(30);
        $display("test %s done", name);
    endtask
    task close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // --------------------------------------------------------
    // Monitor: each end of a pin drive run consumes the oldest note
    // --------------------------------------------------------
    always @(negedge clk) begin
        if (arst_n) begin
            if (oe === 1'b1) begin
                run++;
            end else if (run != 0) begin
                if (notes.size() != 0) begin
                    note = notes.pop_front();
                    chk(cause, note[21:16]);
                    chk(run >= note[15:0], 1);
                end else begin
                    chk(0, 1);
                end
                run = 0;
            end
            if (vf === 1'b1) begin
                chk(rise, 14);
                chk(idle, 1);
                rise = 0;
            end else if (intr === 1'b1 && ckr === 1'b0 && oe === 1'b0) begin
                rise++;
            end
        end
    end
    // A hang counts as a mismatch and ends the run the normal way.
    initial begin
        cyc(20000);
        fails++;
        $display("timeout");
        close_out;
    end
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        cyc(10);
        chk(cause, 6'h02);
        chk({oe, ckr, intr, hiz}, 4'hF);
        cyc(6);
        // The release edge itself is not seen by the monitor, hence 511.
        notes.push_back({6'h02, 16'd511});
        arst_n <= 1'b1;
        settle("power-up");
        hold = 600 + int'(rnd() & 32'hFF);
        notes.push_back({6'h04, 16'(hold)});
        act = 1'b1;
        wdog = 1'b1;
        cyc(2);
        chk(intr, 1);
        chk(ack, 1);
        cyc(hold - 2);
        wdog = 1'b0;
        act = 1'b0;
        settle("watchdog");
        notes.push_back({6'h20, 16'd512});
        instr = 1'b1;
        cyc(1);
        instr = 1'b0;
        cyc(5);
        chk({oe, ckr, intr}, 3'h4);
        settle("instruction");
        // A double fault cuts into an instruction run and takes over.
        notes.push_back({6'h08, 16'd512});
        instr = 1'b1;
        cyc(1);
        instr = 1'b0;
        cyc(100);
        dbl = 1'b1;
        cyc(3);
        dbl = 1'b0;
        settle("double fault");
        r = rnd();
        notes.push_back({6'h10, 16'd512});
        act = 1'b1;
        lock = 1'b1;
        xlong = r[0];
        loss = 1'b1;
        cyc(20);
        chk(mon, 1);
        chk(intr, 0);
        cyc(int'(r[5:1]));
        bend = 1'b1;
        cyc(1);
        bend = 1'b0;
        act = 1'b0;
        lock = 1'b0;
        cyc(5);
        chk(xinv, xlong);
        chk(intr & ckr, 1);
        cyc(600);
        loss = 1'b0;
        settle("loss of clock");
        r = rnd();
        notes.push_back({6'h01, 16'd512});
        p_hold = 16'd590 + 16'(r[5:0]);
        p_go = 1'b1;
        cyc(1);
        p_go = 1'b0;
        cyc(20);
        chk({intr, ckr, oe}, 3'h6);
        settle("external pin");
        chk(notes.size(), 0);
        close_out;
    end
endmodule
